// ==== rdc_top.sv ====
// Rear digital I/O: inputs, outputs, event counter, alarms, scan trigger
`default_nettype none
module rdc_top
  import rdc_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Rear panel pins
  input wire logic [7:0] din_i,
  input wire logic count_in_i,
  input wire logic trigger_input_terminal_n_i,
  output logic [7:0] dout_o,
  output logic [3:0] alarm_n_o,
  // Scan engine
  input wire rdc_scan_res_t scan_res_i,
  output logic scan_start_o,
  // Interrupt
  output logic irq_o
);
  rdc_ctrl_t ctrl_reg;
  logic [7:0] dout_reg;
  logic [15:0] intv_reg;
  logic [3:0][15:0] hi_reg;
  logic [IRQ_W-1:0] ists_reg, imsk_reg;
  logic [15:0] cnt_reg;
  logic overrun_indication_reg;
  logic [3:0] alarm_n_reg;
  logic irq_reg;
  logic [7:0] din_lvl;
  logic cnt_rise, trigger_enable_setting_fall;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic aw_full_reg, w_full_reg;
  logic awready_reg, wready_reg, bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg, rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic wr_go;
  logic [31:0] wmask, wbits;
  logic zero_cmd, preset_cmd, ovr_set, cnt_step;
  logic [31:0] tick_cnt_reg;
  logic tick;
  logic [15:0] intv_cnt_reg;
  logic run_q_reg, due, trigger_enable_setting_scan;
  logic pend_reg, busy_reg, start_reg;
  logic [3:0] above;
  logic [IRQ_W-1:0] ev;

  // Pin synchronisers: data inputs, count input, trigger input
  rdc_sync #(.W(8)) u_din (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .pin_i(din_i),
    .level_o(din_lvl),
    .rise_o(),
    .fall_o()
  );
  rdc_sync #(.W(1)) u_cnt (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .pin_i(count_in_i),
    .level_o(),
    .rise_o(cnt_rise),
    .fall_o()
  );
  rdc_sync #(.W(1)) u_trigger_enable_setting (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .pin_i(trigger_input_terminal_n_i),
    .level_o(),
    .rise_o(),
    .fall_o(trigger_enable_setting_fall)
  );

  // Write path: address and data taken in either order
  assign wr_go = aw_full_reg & w_full_reg & ~bvalid_reg;
  assign wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                  {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
  assign wbits = w_data_reg & wmask;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else begin
      if (s_axi_awvalid && awready_reg) begin
        aw_addr_reg <= s_axi_awaddr;
        aw_full_reg <= 1'b1;
        awready_reg <= 1'b0;
      end
      if (s_axi_wvalid && wready_reg) begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        w_full_reg <= 1'b1;
        wready_reg <= 1'b0;
      end
      if (wr_go) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= (aw_addr_reg > OFF_IMSK || aw_addr_reg[1:0] != 2'b00)
                     ? RESP_SLVERR : RESP_OKAY;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end

  // Byte-lane merge of a write into a stored value
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] m,
                                        input logic [31:0] d);
    merge = (old & ~m) | (d & m);
  endfunction

  assign zero_cmd = wr_go && aw_addr_reg == OFF_CTRL && wbits[3];
  assign preset_cmd = wr_go && aw_addr_reg == OFF_COUNT;

  // Software-written configuration
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ctrl_reg <= CTRL_RST;
      dout_reg <= DOUT_RST;
      intv_reg <= INTV_RST;
      hi_reg <= {4{HI_RST}};
      imsk_reg <= '0;
    end else if (wr_go) begin
      case (aw_addr_reg)
        OFF_CTRL: ctrl_reg <= 4'(merge(32'(ctrl_reg), wmask, w_data_reg))
                              & 4'h7;
        OFF_DOUT: dout_reg <= 8'(merge(32'(dout_reg), wmask,
                                       w_data_reg));
        OFF_INTV: intv_reg <= 16'(merge(32'(intv_reg), wmask, w_data_reg));
        OFF_HI0: hi_reg[0] <= 16'(merge(32'(hi_reg[0]), wmask, w_data_reg));
        OFF_HI1: hi_reg[1] <= 16'(merge(32'(hi_reg[1]), wmask, w_data_reg));
        OFF_HI2: hi_reg[2] <= 16'(merge(32'(hi_reg[2]), wmask, w_data_reg));
        OFF_HI3: hi_reg[3] <= 16'(merge(32'(hi_reg[3]), wmask, w_data_reg));
        OFF_IMSK: imsk_reg <= IRQ_W'(merge(32'(imsk_reg), wmask,
                                           w_data_reg));
        default: ;
      endcase
    end
  end

  // Event counter; host preset beats zero, both beat a count edge
  assign cnt_step = ctrl_reg.cnt_en && cnt_rise && !preset_cmd && !zero_cmd;
  assign ovr_set = cnt_step && cnt_reg == CNT_MAX;
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      cnt_reg <= '0;
      overrun_indication_reg <= 1'b0;
    end else if (preset_cmd) begin
      cnt_reg <= 16'(merge(32'(cnt_reg), wmask, w_data_reg));
      overrun_indication_reg <= 1'b0;
    end else if (zero_cmd) begin
      cnt_reg <= '0;
      overrun_indication_reg <= 1'b0;
    end else if (ovr_set) begin
      overrun_indication_reg <= 1'b1;
    end else if (cnt_step) begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end

  // Millisecond tick; a parameter so simulation can shorten it
  assign tick = tick_cnt_reg == 32'(TICK_CYCLES - 1);
  always_ff @(posedge sys_clk_i) begin
    if (srst_i || tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
    end
  end

  // Interval timer: first scan at run start, then one per interval
  assign due = ctrl_reg.scan_run &&
               (!run_q_reg || (tick && intv_cnt_reg + 16'h0001 >= intv_reg));
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      run_q_reg <= 1'b0;
      intv_cnt_reg <= '0;
    end else begin
      run_q_reg <= ctrl_reg.scan_run;
      if (!ctrl_reg.scan_run || due) begin
        intv_cnt_reg <= '0;
      end else if (tick) begin
        intv_cnt_reg <= intv_cnt_reg + 16'h0001;
      end
    end
  end

  // Trigger scans do not touch the interval timer
  assign trigger_enable_setting_scan = ctrl_reg.trigger_enable_setting_en && trigger_enable_setting_fall;

  // Scan request: a pending request waits until the engine is idle
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      pend_reg <= 1'b0;
      busy_reg <= 1'b0;
      start_reg <= 1'b0;
    end else begin
      start_reg <= 1'b0;
      if (pend_reg && !busy_reg) begin
        start_reg <= 1'b1;
        busy_reg <= 1'b1;
        pend_reg <= due || trigger_enable_setting_scan;
      end else begin
        pend_reg <= pend_reg || due || trigger_enable_setting_scan;
        if (scan_res_i.done) begin
          busy_reg <= 1'b0;
        end
      end
    end
  end

  // Alarms follow each completed scan, channels 0 to 3
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      above[i] = scan_res_i.reading[i] > hi_reg[i];
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      alarm_n_reg <= ALARM_OFF;
    end else if (scan_res_i.done) begin
      alarm_n_reg <= ~above;
    end
  end

  // Sticky interrupt status; a new event wins over a write-one clear
  assign ev = {trigger_enable_setting_scan, scan_res_i.done, ovr_set};
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ists_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      if (wr_go && aw_addr_reg == OFF_ISTS) begin
        ists_reg <= (ists_reg & ~IRQ_W'(wbits)) | ev;
      end else begin
        ists_reg <= ists_reg | ev;
      end
      irq_reg <= |(ists_reg & imsk_reg);
    end
  end

  // Read path
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= RESP_OKAY;
    end else if (s_axi_arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
      case (s_axi_araddr)
        OFF_CTRL: rdata_reg <= 32'(ctrl_reg);
        OFF_DOUT: rdata_reg <= 32'(dout_reg);
        OFF_DIN: rdata_reg <= 32'(din_lvl);
        OFF_COUNT: rdata_reg <= 32'(cnt_reg);
        OFF_STAT: rdata_reg <= 32'({busy_reg, overrun_indication_reg});
        OFF_INTV: rdata_reg <= 32'(intv_reg);
        OFF_HI0: rdata_reg <= 32'(hi_reg[0]);
        OFF_HI1: rdata_reg <= 32'(hi_reg[1]);
        OFF_HI2: rdata_reg <= 32'(hi_reg[2]);
        OFF_HI3: rdata_reg <= 32'(hi_reg[3]);
        OFF_ISTS: rdata_reg <= 32'(ists_reg);
        OFF_IMSK: rdata_reg <= 32'(imsk_reg);
        default: rresp_reg <= RESP_SLVERR;
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  // Outputs straight from flops
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign dout_o = dout_reg;
  assign alarm_n_o = alarm_n_reg;
  assign scan_start_o = start_reg;
  assign irq_o = irq_reg;

  // Checks
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (srst_i);

  a_din_map: assert property (
    ##2 din_lvl == $past(din_i, 2))
    else $error("input byte does not follow pins");
  a_cnt_step: assert property (
    cnt_step && cnt_reg != CNT_MAX |=> cnt_reg == $past(cnt_reg) + 16'h0001)
    else $error("counter did not advance by one");
  a_cnt_preset: assert property (
    preset_cmd && w_strb_reg == 4'hF |=>
      cnt_reg == $past(w_data_reg[15:0]) && !overrun_indication_reg)
    else $error("preset not loaded");
  a_cnt_overrun: assert property (
    ovr_set |=> overrun_indication_reg && cnt_reg == CNT_MAX)
    else $error("overrun not flagged at full count");
  a_cnt_zero: assert property (
    zero_cmd && !preset_cmd |=>
      cnt_reg == 16'h0000 && !overrun_indication_reg && ctrl_reg.cnt_en
        == $past(ctrl_reg.cnt_en))
    else $error("zero request failed");
  a_alarm_reset: assert property (
    @(posedge sys_clk_i) disable iff (1'b0)
      srst_i |=> alarm_n_o == ALARM_OFF)
    else $error("alarms not idle after reset");
  a_alarm_hi: assert property (
    scan_res_i.done |=> alarm_n_o == ~$past(above))
    else $error("alarm does not match scan");
  a_trigger_enable_setting_off: assert property (
    !ctrl_reg.trigger_enable_setting_en && trigger_enable_setting_fall && !due && !pend_reg |=> !pend_reg)
    else $error("trigger acted while disabled");
  a_trigger_enable_setting_scan: assert property (
    trigger_enable_setting_scan && !pend_reg && !busy_reg && !scan_res_i.done |=>
      pend_reg ##1 scan_start_o)
    else $error("trigger did not start a scan");

  c_overrun: cover property (ovr_set);
  c_trigger_enable_setting_scan: cover property (trigger_enable_setting_scan ##[1:4] scan_start_o);
  c_alarm_low: cover property (scan_res_i.done && above != 4'h0);
endmodule
`default_nettype wire

// ==== rdc_pkg.sv ====
// Package: register map, field layout and timing of the rear digital I/O
`default_nettype none
package rdc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_DOUT = 8'h04;
  localparam logic [7:0] OFF_DIN = 8'h08;
  localparam logic [7:0] OFF_COUNT = 8'h0C;
  localparam logic [7:0] OFF_STAT = 8'h10;
  localparam logic [7:0] OFF_INTV = 8'h14;
  localparam logic [7:0] OFF_HI0 = 8'h18;
  localparam logic [7:0] OFF_HI1 = 8'h1C;
  localparam logic [7:0] OFF_HI2 = 8'h20;
  localparam logic [7:0] OFF_HI3 = 8'h24;
  localparam logic [7:0] OFF_ISTS = 8'h28;
  localparam logic [7:0] OFF_IMSK = 8'h2C;
  // Reset values and full count
  localparam logic [3:0] CTRL_RST = 4'h1;
  localparam logic [7:0] DOUT_RST = 8'hFF;
  localparam logic [15:0] INTV_RST = 16'h1388;
  localparam logic [15:0] HI_RST = 16'hFFFF;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [3:0] ALARM_OFF = 4'hF;
  // Interrupt bit positions
  localparam int IRQ_OVR = 0;
  localparam int IRQ_SCAN = 1;
  localparam int IRQ_TRIGGER_ENABLE_SETTING = 2;
  localparam int IRQ_W = 3;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // Interval tick: 1 ms at a 10 ns clock
  localparam int TICK_NS = 1_000_000;
  localparam int CLK_NS = 10;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  // Control register layout, bit 3 down to bit 0
  typedef struct packed {
    logic zero;
    logic scan_run;
    logic trigger_enable_setting_en;
    logic cnt_en;
  } rdc_ctrl_t;
  // Scan result from the measurement engine
  typedef struct packed {
    logic done;
    logic [3:0][15:0] reading;
  } rdc_scan_res_t;
endpackage
`default_nettype wire

// ==== rdc_sync.sv ====
// Two-flop pin synchroniser with edge detect on the settled stage
`default_nettype none
module rdc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // Pin side
  input wire logic [W-1:0] pin_i,
  // Synchronous side
  output logic [W-1:0] level_o,
  output logic [W-1:0] rise_o,
  output logic [W-1:0] fall_o
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;
  logic [W-1:0] prev_reg;

  // Idle pins read high, as open lines do
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      meta_reg <= '1;
      sync_reg <= '1;
      prev_reg <= '1;
    end else begin
      meta_reg <= pin_i;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // Edges only from the second stage, never the first
  assign level_o = sync_reg;
  assign rise_o = sync_reg & ~prev_reg;
  assign fall_o = ~sync_reg & prev_reg;
endmodule
`default_nettype wire

// ==== rdc_far_model.sv ====
// Far-side model: panel contacts, pulse source and scan engine
`default_nettype none
module rdc_far_model
  import rdc_pkg::*;
#(
  parameter int DLY = 3
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // Scan engine side
  input wire logic scan_start_i,
  input wire logic [3:0][15:0] rd_i,
  output rdc_scan_res_t scan_res_o,
  // Panel pins, open lines idle high
  output logic count_o,
  output logic trigger_enable_setting_n_o,
  output logic [7:0] din_o
);
  int busy_cnt = 0;

  // Pins start open
  initial begin
    count_o = 1'b1;
    trigger_enable_setting_n_o = 1'b1;
    din_o = 8'hFF;
    scan_res_o = '0;
  end

  // Scan takes DLY cycles; reading flips outside done so stale data shows
  always @(posedge sys_clk_i) begin
    scan_res_o.done <= 1'b0;
    scan_res_o.reading <= ~scan_res_o.reading;
    if (srst_i) begin
      busy_cnt <= 0;
    end else if (scan_start_i) begin
      busy_cnt <= DLY;
    end else if (busy_cnt != 0) begin
      busy_cnt <= busy_cnt - 1;
      if (busy_cnt == 1) begin
        scan_res_o.done <= 1'b1;
        scan_res_o.reading <= rd_i;
      end
    end
  end

  // Full low-then-high cycles, h clocks per half
  task automatic pulses(input int n, input int h);
    repeat (n) begin
      @(posedge sys_clk_i);
      count_o <= 1'b0;
      repeat (h) @(posedge sys_clk_i);
      count_o <= 1'b1;
      repeat (h - 1) @(posedge sys_clk_i);
    end
  endtask

  // Short the trigger contact to ground for h clocks
  task automatic trigger_enable_setting_pulse(input int h);
    @(posedge sys_clk_i);
    trigger_enable_setting_n_o <= 1'b0;
    repeat (h) @(posedge sys_clk_i);
    trigger_enable_setting_n_o <= 1'b1;
  endtask

  task automatic set_din(input logic [7:0] v);
    @(posedge sys_clk_i);
    din_o <= v;
  endtask
endmodule
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench for the rear digital I/O block
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR t=%0t got %0h exp %0h", $time, g, e); end end
module tb
  import rdc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 10;
  localparam int IV = 4;
  localparam int PER = TK * IV;
  localparam int LIMIT = 20000;
  logic sys_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] s_axi_awaddr = '0;
  logic [7:0] s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [7:0] din_i, dout_o;
  logic count_in_i, trigger_input_terminal_n_i, scan_start_o, irq_o;
  logic [3:0] alarm_n_o;
  rdc_scan_res_t scan_res_i;
  logic [3:0][15:0] rdg = '0;
  logic [31:0] seed = 32'h0000_5ada;
  int n_mismatch = 0;
  int total_checks = 0;
  int cyc = 0;
  int st_q[$];

  rdc_top #(.TICK_CYCLES(TK)) rdc_top_inst (.sys_clk_i, .srst_i,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .din_i,
    .count_in_i, .trigger_input_terminal_n_i, .dout_o, .alarm_n_o,
    .scan_res_i, .scan_start_o, .irq_o);

  rdc_far_model #(.DLY(3)) rdc_far_model_inst (.sys_clk_i, .srst_i,
    .scan_start_i(scan_start_o), .rd_i(rdg), .scan_res_o(scan_res_i),
    .count_o(count_in_i), .trigger_enable_setting_n_o(trigger_input_terminal_n_i),
    .din_o(din_i));

  initial forever #5 sys_clk_i = ~sys_clk_i;

  // Cycle count, hang guard and log of scan start times
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (scan_start_o === 1'b1) st_q.push_back(cyc);
    if (cyc == LIMIT) begin
      n_mismatch++;
      end_sim();
    end
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Alarm pins expected after a scan: low where reading exceeds limit
  function automatic logic [3:0] exp_alarm(input logic [3:0][15:0] r,
                                           input logic [3:0][15:0] h);
    logic [3:0] e;
    for (int n = 0; n < 4; n++) e[n] = !(r[n] > h[n]);
    return e;
  endfunction

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask

  // One write; address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic [1:0] r;
    @(posedge sys_clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge sys_clk_i);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
    `CHK(r, er)
  endtask

  // One read, compared with expected response and data together
  task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er);
    logic [33:0] got;
    @(posedge sys_clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge sys_clk_i);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        got = {s_axi_rresp, s_axi_rdata};
        s_axi_rready <= 1'b0;
        break;
      end
    end
    `CHK(got, {er, e})
  endtask

  task automatic wait_start(output int t);
    do @(posedge sys_clk_i); while (scan_start_o !== 1'b1);
    t = cyc;
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    int t0, k, n0;
    logic [7:0] v;
    logic [31:0] x;
    logic [3:0][15:0] hi;
    repeat (4) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    `CHK(dout_o, 8'hFF)
    `CHK(alarm_n_o, ALARM_OFF)
    rchk(OFF_COUNT, 32'h0, RESP_OKAY);
    rchk(OFF_DIN, 32'hFF, RESP_OKAY);
    wr(8'h3C, 32'h0, RESP_SLVERR);
    rchk(8'h3C, 32'h0, RESP_SLVERR);
    $display("test reset done");
    // Walk a grounded line and a low output over all eight positions
    for (int n = 0; n < 8; n++) begin
      v = ~(8'h01 << n);
      rdc_far_model_inst.set_din(v);
      wr(OFF_DOUT, {24'h0, v}, RESP_OKAY);
      `CHK(dout_o, v)
      rchk(OFF_DIN, {24'h0, v}, RESP_OKAY);
    end
    x = rnd();
    wr(OFF_DOUT, x, RESP_OKAY);
    `CHK(dout_o, x[7:0])
    $display("test dio done");
    // Slow pulses, then a fast periodic train
    x = rnd();
    n0 = int'(x[1:0]) + 2;
    rdc_far_model_inst.pulses(n0, 3);
    idle(6);
    rchk(OFF_COUNT, 32'(n0), RESP_OKAY);
    rdc_far_model_inst.pulses(20, 2);
    idle(6);
    rchk(OFF_COUNT, 32'(n0 + 20), RESP_OKAY);
    x = rnd();
    wr(OFF_COUNT, {16'h0, x[15:0]}, RESP_OKAY);
    rchk(OFF_COUNT, {16'h0, x[15:0]}, RESP_OKAY);
    // Top of range, then one count past it
    wr(OFF_COUNT, 32'hFFFE, RESP_OKAY);
    rdc_far_model_inst.pulses(1, 3);
    idle(6);
    rchk(OFF_COUNT, 32'hFFFF, RESP_OKAY);
    rchk(OFF_STAT, 32'h0, RESP_OKAY);
    rdc_far_model_inst.pulses(1, 3);
    idle(6);
    rchk(OFF_COUNT, 32'hFFFF, RESP_OKAY);
    rchk(OFF_STAT, 32'h1, RESP_OKAY);
    rchk(OFF_ISTS, 32'h1, RESP_OKAY);
    // Interrupt raised, masked, unmasked, cleared
    wr(OFF_IMSK, 32'h1, RESP_OKAY);
    idle(2);
    `CHK(irq_o, 1'b1)
    wr(OFF_IMSK, 32'h0, RESP_OKAY);
    idle(2);
    `CHK(irq_o, 1'b0)
    wr(OFF_IMSK, 32'h1, RESP_OKAY);
    wr(OFF_ISTS, 32'h1, RESP_OKAY);
    idle(2);
    `CHK(irq_o, 1'b0)
    rchk(OFF_STAT, 32'h1, RESP_OKAY);
    // Zero request keeps counting selected
    wr(OFF_CTRL, 32'h9, RESP_OKAY);
    rchk(OFF_COUNT, 32'h0, RESP_OKAY);
    rchk(OFF_STAT, 32'h0, RESP_OKAY);
    rdc_far_model_inst.pulses(3, 3);
    idle(6);
    rchk(OFF_COUNT, 32'h3, RESP_OKAY);
    $display("test counter done");
    // Limits at and one below the readings, then interval scanning
    for (int n = 0; n < 4; n++) begin
      x = rnd();
      hi[n] = {1'b0, x[14:0]};
      rdg[n] <= hi[n] + 16'(n % 2);
      wr(OFF_HI0 + 8'(4 * n), {16'h0, hi[n]}, RESP_OKAY);
    end
    wr(OFF_INTV, 32'(IV), RESP_OKAY);
    wr(OFF_CTRL, 32'h5, RESP_OKAY);
    wait_start(t0);
    idle(6);
    `CHK(alarm_n_o, exp_alarm(rdg, hi))
    k = st_q.size();
    idle(10 * PER);
    `CHK(st_q.size() - k, 10)
    rdg <= '0;
    wait_start(t0);
    idle(6);
    `CHK(alarm_n_o, ALARM_OFF)
    $display("test scan done");
    // Trigger between interval scans
    wr(OFF_CTRL, 32'h7, RESP_OKAY);
    wait_start(t0);
    idle(1); // Let the logger take this start before counting
    k = st_q.size();
    idle(14);
    rdc_far_model_inst.trigger_enable_setting_pulse(3);
    idle(PER);
    `CHK(st_q.size() - k, 2)
    `CHK(st_q[k] - t0 < PER, 1'b1)
    `CHK(st_q[k + 1] - t0, PER)
    // Trigger ignored when disabled, single scan when enabled
    wr(OFF_CTRL, 32'h1, RESP_OKAY);
    idle(PER);
    k = st_q.size();
    rdc_far_model_inst.trigger_enable_setting_pulse(3);
    idle(20);
    `CHK(st_q.size() - k, 0)
    wr(OFF_CTRL, 32'h3, RESP_OKAY);
    rdc_far_model_inst.trigger_enable_setting_pulse(3);
    idle(20);
    `CHK(st_q.size() - k, 1)
    rchk(OFF_ISTS, 32'h6, RESP_OKAY);
    $display("test trigger done");
    end_sim();
  end
endmodule
`default_nettype wire
